// File: core/bif_map.svh
`ifndef BIF_MAP_SVH
`define BIF_MAP_SVH
`define BIF_ID_OCC 8'h01
`define BIF_ID_SW 8'h0B
`define BIF_ID_CH 8'h12
`define BIF_LEN_SW 8'h04
`define BIF_LEN_CH 8'h02
`define BIF_CODE_FREE 2'h0
`define BIF_CODE_FIXED 2'h1
`define BIF_CODE_NOISE 2'h2
`define BIF_CODE_MOVABLE 2'h3
`define BIF_BCAST_ADDR 16'hFFFF
`define BIF_MAX_SLOTS 8'h20
`define BIF_SLOTS_PER_OCT 8'h04
`define BIF_OFF_CTRL 12'h000
`define BIF_OFF_SWITCH 12'h004
`define BIF_OFF_CHAN 12'h008
`define BIF_OFF_STATUS 12'h00C
`define BIF_SW_BYTES 8'h05
`define BIF_CH_BYTES 8'h03
`define BIF_OCC_HDR_LAST 8'h02
`endif

// File: core/bif_pkg.sv
package bif_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_OCC = 6'b00_0010,
    ST_BMP = 6'b00_0100,
    ST_ADDR = 6'b00_1000,
    ST_SW = 6'b01_0000,
    ST_CH = 6'b10_0000
  } bif_state_t;
  typedef logic [1:0] bif_code_t;
endpackage : bif_pkg

// File: core/bif_framer.sv
// The implementer's own choices: the register addresses and the APB interface to the registers.
`include "bif_map.svh"
module bif_framer
  import bif_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic obs_valid,
  input wire logic [4:0] obs_slot,
  input wire logic obs_activity,
  input wire logic obs_aligned,
  input wire logic obs_movable,
  input wire logic obs_hibernating,
  input wire logic obs_hdr_check_err,
  input wire logic [15:0] obs_addr,
  input wire logic sf_tick,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  output logic bp_switch_pulse,
  output logic [7:0] new_slot_shift,
  output logic [15:0] new_start_delay,
  output logic ch_switch_pulse,
  output logic [7:0] new_channel
);
  logic [7:0] plen_reg, sw_cnt_reg, sw_off_reg, ch_cnt_reg, ch_num_reg;
  logic [7:0] idx_reg, idx_next, left_reg, left_next, k_oct, occ_n, len_occ, byte_next, bmp_mask;
  logic [15:0] sw_delay_reg, enc_addr;
  logic sw_armed_reg, sw_sent_reg, ch_armed_reg, ch_sent_reg, half_reg, half_next;
  logic emit, last_next, advance, busy, start;
  bif_code_t slot_code_reg [32];
  logic [15:0] slot_addr_reg [32];
  bif_state_t state_reg, state_next, after_occ;
  bif_code_t enc_code;
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign busy = (state_reg != ST_IDLE);
  assign start = sf_tick && !busy;
  assign advance = !tx_valid || tx_ready;
  assign k_oct = 8'((9'(plen_reg) + 9'(`BIF_SLOTS_PER_OCT) - 9'd1) >> 2);
  assign len_occ = 8'(8'd1 + k_oct + {occ_n[6:0], 1'b0});
  assign after_occ = sw_armed_reg ? ST_SW : (ch_armed_reg ? ST_CH : ST_IDLE);
  always_comb begin
    occ_n = 8'h00;
    for (int s = 0; s < 32; s++) begin
      if (8'(s) < plen_reg && slot_code_reg[s] != `BIF_CODE_FREE) begin
        occ_n = 8'(occ_n + 8'd1);
      end
    end
  end
  // slot status encoding, aligned beacon takes precedence over raw activity
  always_comb begin
    enc_code = `BIF_CODE_FREE;
    enc_addr = 16'h0000;
    if (obs_aligned) begin
      enc_code = obs_movable ? `BIF_CODE_MOVABLE : `BIF_CODE_FIXED;
      enc_addr = obs_addr;
    end else if (obs_hibernating) begin
      enc_code = `BIF_CODE_FIXED;
      enc_addr = obs_addr;
    end else if (obs_activity) begin
      enc_code = `BIF_CODE_NOISE;
      enc_addr = obs_hdr_check_err ? obs_addr : `BIF_BCAST_ADDR;
    end
  end
  // observations refused while a frame is being built so the image stays coherent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < 32; s++) begin
        slot_code_reg[s] <= `BIF_CODE_FREE;
        slot_addr_reg[s] <= 16'h0000;
      end
    end else if (obs_valid && !busy) begin
      slot_code_reg[obs_slot] <= enc_code;
      slot_addr_reg[obs_slot] <= enc_addr;
    end
  end
  always_comb begin
    bmp_mask = 8'h00;
    for (int j = 0; j < 4; j++) begin
      if ({3'b000, idx_reg[2:0], 2'(j)} < plen_reg) begin
        bmp_mask[2*j +: 2] = slot_code_reg[{idx_reg[2:0], 2'(j)}];
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    left_next = left_reg;
    half_next = half_reg;
    emit = 1'b0;
    byte_next = 8'h00;
    last_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_OCC;
          idx_next = 8'h00;
          left_next = occ_n;
          half_next = 1'b0;
        end
      end
      ST_OCC: begin
        if (advance) begin
          emit = 1'b1;
          idx_next = 8'(idx_reg + 8'd1);
          case (idx_reg)
            8'h00: byte_next = `BIF_ID_OCC;
            8'h01: byte_next = len_occ;
            default: byte_next = plen_reg;
          endcase
          if (idx_reg == `BIF_OCC_HDR_LAST) begin
            idx_next = 8'h00;
            state_next = (k_oct != 8'h00) ? ST_BMP : after_occ;
            last_next = (k_oct == 8'h00) && (after_occ == ST_IDLE);
          end
        end
      end
      ST_BMP: begin
        if (advance) begin
          emit = 1'b1;
          byte_next = bmp_mask;
          idx_next = 8'(idx_reg + 8'd1);
          if (idx_reg == 8'(k_oct - 8'd1)) begin
            idx_next = 8'h00;
            state_next = (left_reg != 8'h00) ? ST_ADDR : after_occ;
            last_next = (left_reg == 8'h00) && (after_occ == ST_IDLE);
          end
        end
      end
      ST_ADDR: begin
        if (advance) begin
          if (slot_code_reg[idx_reg[4:0]] == `BIF_CODE_FREE) begin
            idx_next = 8'(idx_reg + 8'd1);
          end else if (!half_reg) begin
            emit = 1'b1;
            byte_next = slot_addr_reg[idx_reg[4:0]][7:0];
            half_next = 1'b1;
          end else begin
            emit = 1'b1;
            byte_next = slot_addr_reg[idx_reg[4:0]][15:8];
            half_next = 1'b0;
            idx_next = 8'(idx_reg + 8'd1);
            left_next = 8'(left_reg - 8'd1);
            if (left_reg == 8'h01) begin
              idx_next = 8'h00;
              state_next = after_occ;
              last_next = (after_occ == ST_IDLE);
            end
          end
        end
      end
      ST_SW: begin
        if (advance) begin
          emit = 1'b1;
          idx_next = 8'(idx_reg + 8'd1);
          case (idx_reg)
            8'h00: byte_next = `BIF_ID_SW;
            8'h01: byte_next = `BIF_LEN_SW;
            8'h02: byte_next = sw_cnt_reg;
            8'h03: byte_next = sw_off_reg;
            8'h04: byte_next = sw_delay_reg[7:0];
            default: byte_next = sw_delay_reg[15:8];
          endcase
          if (idx_reg == `BIF_SW_BYTES) begin
            idx_next = 8'h00;
            state_next = ch_armed_reg ? ST_CH : ST_IDLE;
            last_next = !ch_armed_reg;
          end
        end
      end
      ST_CH: begin
        if (advance) begin
          emit = 1'b1;
          idx_next = 8'(idx_reg + 8'd1);
          case (idx_reg)
            8'h00: byte_next = `BIF_ID_CH;
            8'h01: byte_next = `BIF_LEN_CH;
            8'h02: byte_next = ch_cnt_reg;
            default: byte_next = ch_num_reg;
          endcase
          if (idx_reg == `BIF_CH_BYTES) begin
            idx_next = 8'h00;
            state_next = ST_IDLE;
            last_next = 1'b1;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      idx_reg <= 8'h00;
      left_reg <= 8'h00;
      half_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      left_reg <= left_next;
      half_reg <= half_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
    end else if (advance) begin
      tx_valid <= emit;
      tx_data <= byte_next;
      tx_last <= last_next;
    end
  end
  // a software write arms a countdown and wins over a same-cycle disarm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_cnt_reg <= 8'h00;
      sw_off_reg <= 8'h00;
      sw_delay_reg <= 16'h0000;
      sw_armed_reg <= 1'b0;
      sw_sent_reg <= 1'b0;
      bp_switch_pulse <= 1'b0;
      new_slot_shift <= 8'h00;
      new_start_delay <= 16'h0000;
    end else begin
      bp_switch_pulse <= 1'b0;
      if (start && sw_armed_reg) begin
        sw_sent_reg <= 1'b1;
        if (sw_sent_reg && sw_cnt_reg == 8'h00) begin
          bp_switch_pulse <= 1'b1;
          new_slot_shift <= sw_off_reg;
          new_start_delay <= sw_delay_reg;
          sw_armed_reg <= 1'b0;
        end else if (sw_sent_reg) begin
          sw_cnt_reg <= 8'(sw_cnt_reg - 8'd1);
        end
      end
      if (psel && penable && pwrite && paddr == `BIF_OFF_SWITCH) begin
        sw_cnt_reg <= pwdata[7:0];
        sw_off_reg <= pwdata[15:8];
        sw_delay_reg <= pwdata[31:16];
        sw_armed_reg <= 1'b1;
        sw_sent_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_cnt_reg <= 8'h00;
      ch_num_reg <= 8'h00;
      ch_armed_reg <= 1'b0;
      ch_sent_reg <= 1'b0;
      ch_switch_pulse <= 1'b0;
      new_channel <= 8'h00;
    end else begin
      ch_switch_pulse <= 1'b0;
      if (start && ch_armed_reg) begin
        ch_sent_reg <= 1'b1;
        if (ch_sent_reg && ch_cnt_reg == 8'h00) begin
          ch_switch_pulse <= 1'b1;
          new_channel <= ch_num_reg;
          ch_armed_reg <= 1'b0;
        end else if (ch_sent_reg) begin
          ch_cnt_reg <= 8'(ch_cnt_reg - 8'd1);
        end
      end
      if (psel && penable && pwrite && paddr == `BIF_OFF_CHAN) begin
        ch_cnt_reg <= pwdata[7:0];
        ch_num_reg <= pwdata[15:8];
        ch_armed_reg <= 1'b1;
        ch_sent_reg <= 1'b0;
      end
    end
  end
  // period length saturates at the slot store depth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plen_reg <= 8'h00;
    end else if (psel && penable && pwrite && paddr == `BIF_OFF_CTRL && !busy) begin
      plen_reg <= (pwdata[7:0] > `BIF_MAX_SLOTS) ? `BIF_MAX_SLOTS : pwdata[7:0];
    end
  end
  // zero-wait slave: read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
        case (paddr)
          `BIF_OFF_CTRL: prdata <= {24'h00_0000, plen_reg};
          `BIF_OFF_SWITCH: prdata <= {sw_delay_reg, sw_off_reg, sw_cnt_reg};
          `BIF_OFF_CHAN: prdata <= {16'h0000, ch_num_reg, ch_cnt_reg};
          `BIF_OFF_STATUS: prdata <= {ch_cnt_reg, sw_cnt_reg, occ_n, 5'h00, ch_armed_reg, sw_armed_reg, busy};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
  property p_occ_id;
    (state_reg == ST_OCC && idx_reg == 8'h00 && advance) |=> tx_valid && tx_data == `BIF_ID_OCC;
  endproperty
  a_occ_id: assert property (p_occ_id) else $error("occupancy id wrong");
  property p_occ_len;
    (state_reg == ST_OCC && idx_reg == 8'h01 && advance) |=> tx_data == $past(len_occ);
  endproperty
  a_occ_len: assert property (p_occ_len) else $error("occupancy length wrong");
  property p_plen;
    (state_reg == ST_OCC && idx_reg == 8'h02 && advance) |=> tx_data == plen_reg;
  endproperty
  a_plen: assert property (p_plen) else $error("period length octet wrong");
  property p_free;
    (obs_valid && !busy && !obs_activity && !obs_aligned && !obs_hibernating)
      |=> slot_code_reg[$past(obs_slot)] == `BIF_CODE_FREE;
  endproperty
  a_free: assert property (p_free) else $error("quiet slot not free");
  property p_movable;
    (obs_valid && !busy && obs_aligned && obs_movable)
      |=> slot_code_reg[$past(obs_slot)] == `BIF_CODE_MOVABLE && slot_addr_reg[$past(obs_slot)] == $past(obs_addr);
  endproperty
  a_movable: assert property (p_movable) else $error("movable beacon misencoded");
  property p_bcast;
    (obs_valid && !busy && obs_activity && !obs_aligned && !obs_hibernating && !obs_hdr_check_err)
      |=> slot_addr_reg[$past(obs_slot)] == `BIF_BCAST_ADDR;
  endproperty
  a_bcast: assert property (p_bcast) else $error("noise slot address not broadcast");
  // judged per accepted octet, so a stalled sink holding the id octet is legal
  property p_sw_len;
    (state_reg == ST_SW && idx_reg <= 8'h01 && advance)
      |=> tx_valid && tx_data == ($past(idx_reg[0]) ? `BIF_LEN_SW : `BIF_ID_SW);
  endproperty
  a_sw_len: assert property (p_sw_len) else $error("switch header wrong");
  property p_ch_len;
    (state_reg == ST_CH && idx_reg == 8'h01 && advance) |=> tx_data == `BIF_LEN_CH;
  endproperty
  a_ch_len: assert property (p_ch_len) else $error("channel length wrong");
  property p_dec;
    (start && sw_armed_reg && sw_sent_reg && sw_cnt_reg != 8'h00 && !(psel && penable && pwrite))
      |=> sw_cnt_reg == 8'($past(sw_cnt_reg) - 8'd1) && !bp_switch_pulse;
  endproperty
  a_dec: assert property (p_dec) else $error("countdown not decremented");
  property p_fire;
    (start && ch_armed_reg && ch_sent_reg && ch_cnt_reg == 8'h00) |=> ch_switch_pulse ##1 !ch_switch_pulse;
  endproperty
  a_fire: assert property (p_fire) else $error("channel switch not one pulse");
  property p_addr_lo;
    (state_reg == ST_ADDR && advance && !half_reg && slot_code_reg[idx_reg[4:0]] != `BIF_CODE_FREE)
      |=> tx_valid && tx_data == $past(slot_addr_reg[idx_reg[4:0]][7:0]);
  endproperty
  a_addr_lo: assert property (p_addr_lo) else $error("address octet wrong");
  c_frame: cover property (tx_valid && tx_last && tx_ready);
  c_bp_switch: cover property (bp_switch_pulse);
  c_ch_switch: cover property (ch_switch_pulse);
  c_stall: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
endmodule : bif_framer

// File: test/bif_sink.sv
module bif_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  int last_idx = -1;
  int frames = 0;
  // a stalling sink toggles ready so the framer must hold every octet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= stall ? ~tx_ready : 1'b1;
    end
  end
  // octets are taken only when valid and ready meet at an edge
  always @(posedge pclk) begin
    if (presetn && tx_valid === 1'b1 && tx_ready) begin
      got.push_back(tx_data);
      if (tx_last === 1'b1) begin
        last_idx = got.size() - 1;
        frames++;
      end
    end
  end
endmodule : bif_sink

// File: test/tb.sv
`include "bif_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic obs_valid, obs_activity, obs_aligned, obs_movable, obs_hibernating, obs_hdr_check_err;
  logic [4:0] obs_slot;
  logic [15:0] obs_addr, new_start_delay;
  logic sf_tick, tx_valid, tx_last, tx_ready, bp_switch_pulse, ch_switch_pulse, stall;
  logic [7:0] tx_data, new_slot_shift, new_channel;
  int error_cnt = 0;
  int checks_done = 0;
  int bp_cnt = 0;
  int ch_cnt = 0;

  bif_framer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .obs_valid(obs_valid), .obs_slot(obs_slot), .obs_activity(obs_activity), .obs_aligned(obs_aligned),
    .obs_movable(obs_movable), .obs_hibernating(obs_hibernating), .obs_hdr_check_err(obs_hdr_check_err),
    .obs_addr(obs_addr), .sf_tick(sf_tick), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .bp_switch_pulse(bp_switch_pulse), .new_slot_shift(new_slot_shift),
    .new_start_delay(new_start_delay), .ch_switch_pulse(ch_switch_pulse), .new_channel(new_channel));
  bif_sink sink (.pclk(pclk), .presetn(presetn), .stall(stall), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (bp_switch_pulse === 1'b1) bp_cnt++;
    if (ch_switch_pulse === 1'b1) ch_cnt++;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task end_of_test;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
           output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(32'(pready), 32'h0000_0001);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(32'(e), 32'h0000_0000);
  endtask : wr

  task obs(input logic [4:0] s, input logic [4:0] f, input logic [15:0] a);
    @(posedge pclk);
    obs_valid <= 1'b1;
    obs_slot <= s;
    {obs_activity, obs_aligned, obs_movable, obs_hibernating, obs_hdr_check_err} <= f;
    obs_addr <= a;
    @(posedge pclk);
    obs_valid <= 1'b0;
  endtask : obs

  task frame(input logic [7:0] exp[$]);
    int base;
    int f0;
    int n;
    base = sink.got.size();
    f0 = sink.frames;
    @(posedge pclk);
    sf_tick <= 1'b1;
    @(posedge pclk);
    sf_tick <= 1'b0;
    n = 0;
    while (sink.frames == f0 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n < 500), 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk(32'(sink.got.size() - base), 32'(exp.size()));
    foreach (exp[i]) chk(32'(sink.got[base + i]), 32'(exp[i]));
    chk(32'(sink.last_idx), 32'(base + exp.size() - 1));
  endtask : frame

  task t_empty;
    wr(`BIF_OFF_CTRL, 32'h0000_0000);
    frame('{8'h01, 8'h01, 8'h00});
  endtask : t_empty

  // slot 6 lies beyond the period and must vanish from bitmap and list
  task t_occ;
    logic [31:0] st;
    logic e;
    stall <= 1'b1;
    obs(5'd0, 5'b00000, 16'h0A0A);
    obs(5'd1, 5'b11000, 16'h1201);
    obs(5'd2, 5'b11100, 16'h2202);
    obs(5'd3, 5'b10001, 16'h3303);
    obs(5'd4, 5'b10000, 16'h4404);
    obs(5'd5, 5'b00010, 16'h5505);
    obs(5'd6, 5'b10000, 16'h6606);
    wr(`BIF_OFF_CTRL, 32'h0000_0006);
    apb(1'b0, `BIF_OFF_STATUS, 32'h0000_0000, st, e);
    chk(32'(st[2:0]), 32'h0000_0000);
    chk(32'(st[15:8]), 32'h0000_0005);
    frame('{8'h01, 8'h0D, 8'h06, 8'hB4, 8'h06, 8'h01, 8'h12, 8'h02, 8'h22,
            8'h03, 8'h33, 8'hFF, 8'hFF, 8'h05, 8'h55});
    stall <= 1'b0;
  endtask : t_occ

  task t_sw;
    logic [31:0] st;
    logic e;
    stall <= 1'b1;
    wr(`BIF_OFF_CTRL, 32'h0000_0000);
    wr(`BIF_OFF_SWITCH, 32'h1234_0301);
    wr(`BIF_OFF_CHAN, 32'h0000_0900);
    apb(1'b0, `BIF_OFF_STATUS, 32'h0000_0000, st, e);
    chk(32'(st[2:1]), 32'h0000_0003);
    chk(32'(st[23:16]), 32'h0000_0001);
    frame('{8'h01, 8'h01, 8'h00, 8'h0B, 8'h04, 8'h01, 8'h03, 8'h34, 8'h12,
            8'h12, 8'h02, 8'h00, 8'h09});
    chk(32'(ch_cnt), 32'h0000_0000);
    frame('{8'h01, 8'h01, 8'h00, 8'h0B, 8'h04, 8'h00, 8'h03, 8'h34, 8'h12});
    chk(32'(ch_cnt), 32'h0000_0001);
    chk(32'(new_channel), 32'h0000_0009);
    chk(32'(bp_cnt), 32'h0000_0000);
    stall <= 1'b0;
    frame('{8'h01, 8'h01, 8'h00});
    chk(32'(bp_cnt), 32'h0000_0001);
    chk(32'(new_slot_shift), 32'h0000_0003);
    chk(32'(new_start_delay), 32'h0000_1234);
    chk(32'(ch_cnt), 32'h0000_0001);
    apb(1'b0, `BIF_OFF_STATUS, 32'h0000_0000, st, e);
    chk(32'(st[2:1]), 32'h0000_0000);
  endtask : t_sw

  task t_apb;
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h010, 32'h0000_0000, r, e);
    chk(32'(e), 32'h0000_0001);
    chk(r, 32'h0000_0000);
    wr(`BIF_OFF_CTRL, 32'h0000_0040);
    apb(1'b0, `BIF_OFF_CTRL, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0020);
  endtask : t_apb

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, obs_valid, sf_tick, stall} = 6'h00;
    {obs_activity, obs_aligned, obs_movable, obs_hibernating, obs_hdr_check_err} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    obs_slot = 5'h00;
    obs_addr = 16'h0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_empty;
    t_occ;
    t_sw;
    t_apb;
    end_of_test;
  end

  // the whole sequence needs a few hundred cycles, far below the 10000-cycle limit
  initial begin
    #100000;
    error_cnt++;
    end_of_test;
  end
endmodule : tb
